// ===== iam_addr_matcher.sv
`include "iam_defines.svh"

module iam_addr_matcher (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // bus events from the bit engine, one-cycle pulses
  input  wire logic       start_seen,
  input  wire logic       stop_seen,
  input  wire logic       byte_done,
  input  wire logic [7:0] rx_byte,
  // own address configuration
  input  wire logic [6:0] primary_address,
  input  wire logic [2:0] extension_bits,
  input  wire logic       extended_address_enable,
  input  wire logic [6:0] second_address,
  input  wire logic       second_address_enable,
  input  wire logic [6:0] range_address,
  input  wire logic       range_match_enable,
  input  wire logic       general_call_enable,
  input  wire logic       alert_response_enable,
  // interrupt control
  input  wire logic       module_interrupt_enable,
  input  wire logic       interrupt_flag_clear,
  // rate selection
  input  wire logic [5:0] bus_rate_select,
  // addressing answer
  output      logic       address_ack,
  output      logic       addressed_as_slave_flag,
  output      logic       slave_transmit,
  output      logic       read_requested,
  output      logic       general_call_hit,
  output      logic       alert_response_hit,
  // interrupt
  output      logic       module_interrupt_flag,
  output      logic       interrupt_request,
  // decoded rate counts
  output      logic [11:0] scl_divider,
  output      logic [11:0] sda_hold,
  output      logic [11:0] start_hold,
  output      logic [11:0] stop_hold
);

  // ****************************************
  // rate lookup
  // ****************************************
  iam_pkg::iam_rate_s rate;
  iam_pkg::iam_rate_s rate_q;

  iam_rate_lut u_rate_lut (
    .bus_rate_select (bus_rate_select),
    .rate            (rate)
  );

  // registered so the counts never glitch while the code changes
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_q <= {4{`IAM_RESET_COUNT}};
    end else begin
      rate_q <= rate;
    end
  end

  assign scl_divider = rate_q.scl_divider;
  assign sda_hold    = rate_q.sda_hold;
  assign start_hold  = rate_q.start_hold;
  assign stop_hold   = rate_q.stop_hold;

  // ****************************************
  // received byte fields
  // ****************************************
  logic [6:0] rx_addr;
  logic       rx_dir;
  logic [4:0] rx_prefix;
  logic [1:0] rx_upper;
  logic       prefix_hit;

  assign rx_addr    = rx_byte[`IAM_ADDR_MSB:`IAM_ADDR_LSB];
  assign rx_dir     = rx_byte[`IAM_DIR_BIT];
  assign rx_prefix  = rx_byte[`IAM_PREFIX_MSB:`IAM_PREFIX_LSB];
  assign rx_upper   = rx_byte[`IAM_UPPER_MSB:`IAM_UPPER_LSB];
  // a 10-bit first byte is only recognised when this slave is 10-bit
  assign prefix_hit = extended_address_enable && (rx_prefix == `IAM_TEN_BIT_PREFIX);

  // ****************************************
  // 7-bit comparisons
  // ****************************************
  logic primary_hit;
  logic second_hit;
  logic gc_hit;
  logic alert_hit;
  logic range_hit;
  logic any_7bit_hit;

  // primary only serves as a 7-bit address while not extended
  iam_addr_cmp u_cmp_primary (
    .rx_addr  (rx_addr),
    .rx_dir   (rx_dir),
    .own_addr (primary_address),
    .enable   (!extended_address_enable),
    .hit      (primary_hit)
  );

  iam_addr_cmp u_cmp_second (
    .rx_addr  (rx_addr),
    .rx_dir   (rx_dir),
    .own_addr (second_address),
    .enable   (second_address_enable),
    .hit      (second_hit)
  );

  iam_addr_cmp #(
    .CHECK_DIR (1'b1),
    .DIR_VALUE (`IAM_DIR_WRITE)
  ) u_cmp_general_call (
    .rx_addr  (rx_addr),
    .rx_dir   (rx_dir),
    .own_addr (`IAM_GENERAL_CALL_ADDR),
    .enable   (general_call_enable),
    .hit      (gc_hit)
  );

  iam_addr_cmp #(
    .CHECK_DIR (1'b1),
    .DIR_VALUE (`IAM_DIR_READ)
  ) u_cmp_alert (
    .rx_addr  (rx_addr),
    .rx_dir   (rx_dir),
    .own_addr (`IAM_ALERT_RESPONSE_ADDR),
    .enable   (alert_response_enable),
    .hit      (alert_hit)
  );

  // primary itself is excluded, the range value included
  assign range_hit = range_match_enable && (range_address != `IAM_RANGE_OFF)
                     && (rx_addr > primary_address)
                     && (rx_addr <= range_address);

  // a 10-bit prefix never falls through to the 7-bit comparisons
  assign any_7bit_hit = !prefix_hit
                        && (primary_hit || second_hit || gc_hit || alert_hit || range_hit);

  // ****************************************
  // 10-bit comparisons
  // ****************************************
  logic       first_write_hit;
  logic       readdress_hit;
  logic       second_byte_hit;
  logic [6:0] first_addr;
  logic       was_ten_bit;

  // first byte after START: upper bits match, direction write
  assign first_write_hit = prefix_hit
                           && (rx_upper == extension_bits[2:1])
                           && (rx_dir == `IAM_DIR_WRITE);
  // first byte after Sr: same seven bits as before, direction read
  assign readdress_hit   = prefix_hit && was_ten_bit
                           && (rx_addr == first_addr)
                           && (rx_dir == `IAM_DIR_READ);
  // second byte carries the low eight address bits
  assign second_byte_hit = (rx_byte == {extension_bits[`IAM_EXT_LOW_BIT], primary_address});

  // ****************************************
  // addressing state
  // ****************************************
  iam_pkg::iam_state_e state;
  iam_pkg::iam_state_e next_state;
  logic [6:0]          next_first_addr;
  logic                next_was_ten_bit;
  logic                next_addressed;
  logic                next_transmit;
  logic                next_read_req;
  logic                next_ack;
  logic                next_gc;
  logic                next_alert;
  logic                match_event;

  // decides on each address byte; data bytes leave the state alone
  always_comb begin
    next_state       = state;
    next_first_addr  = first_addr;
    next_was_ten_bit = was_ten_bit;
    next_addressed   = addressed_as_slave_flag;
    next_transmit    = slave_transmit;
    next_read_req    = read_requested;
    next_ack         = 1'b0;
    next_gc          = general_call_hit;
    next_alert       = alert_response_hit;
    match_event      = 1'b0;
    if (stop_seen) begin
      // stop always ends the addressed phase
      next_state       = iam_pkg::IAM_IDLE;
      next_addressed   = 1'b0;
      next_transmit    = 1'b0;
      next_was_ten_bit = 1'b0;
    end else if (start_seen) begin
      // addressed flag held over until the next address decides
      next_state = iam_pkg::IAM_FIRST_BYTE;
    end else if (byte_done) begin
      unique case (state)
        iam_pkg::IAM_FIRST_BYTE: begin
          next_gc    = 1'b0;
          next_alert = 1'b0;
          if (readdress_hit) begin
            // master turned round after Sr; this slave now sends
            next_ack       = 1'b1;
            next_addressed = 1'b1;
            next_transmit  = 1'b1;
            next_read_req  = 1'b1;
            match_event    = 1'b1;
            next_state     = iam_pkg::IAM_ADDRESSED;
          end else if (first_write_hit) begin
            // several slaves may ack here; second byte settles it
            next_ack         = 1'b1;
            next_first_addr  = rx_addr;
            next_addressed   = 1'b0;
            next_transmit    = 1'b0;
            next_was_ten_bit = 1'b0;
            match_event      = 1'b1;
            next_state       = iam_pkg::IAM_SECOND_BYTE;
          end else if (any_7bit_hit) begin
            next_ack         = 1'b1;
            next_addressed   = 1'b1;
            next_transmit    = 1'b0;
            next_read_req    = rx_dir;
            next_was_ten_bit = 1'b0;
            next_gc          = gc_hit;
            next_alert       = alert_hit;
            match_event      = 1'b1;
            next_state       = iam_pkg::IAM_ADDRESSED;
          end else begin
            // a read readdress without a prior match is not ours
            next_addressed   = 1'b0;
            next_transmit    = 1'b0;
            next_was_ten_bit = 1'b0;
            next_state       = iam_pkg::IAM_IGNORE;
          end
        end
        iam_pkg::IAM_SECOND_BYTE: begin
          if (second_byte_hit) begin
            next_ack         = 1'b1;
            next_addressed   = 1'b1;
            next_transmit    = 1'b0;
            next_read_req    = 1'b0;
            next_was_ten_bit = 1'b1;
            match_event      = 1'b1;
            next_state       = iam_pkg::IAM_ADDRESSED;
          end else begin
            next_state = iam_pkg::IAM_IGNORE;
          end
        end
        iam_pkg::IAM_IDLE,
        iam_pkg::IAM_ADDRESSED,
        iam_pkg::IAM_IGNORE: begin
          next_state = state;
        end
      endcase
    end
  end

  // registers of the addressing state
  always_ff @(posedge clock) begin
    if (rst) begin
      state                   <= iam_pkg::IAM_IDLE;
      first_addr              <= `IAM_RESET_BYTE7;
      was_ten_bit             <= 1'b0;
      addressed_as_slave_flag <= 1'b0;
      slave_transmit          <= 1'b0;
      read_requested          <= 1'b0;
      address_ack             <= 1'b0;
      general_call_hit        <= 1'b0;
      alert_response_hit      <= 1'b0;
    end else begin
      state                   <= next_state;
      first_addr              <= next_first_addr;
      was_ten_bit             <= next_was_ten_bit;
      addressed_as_slave_flag <= next_addressed;
      slave_transmit          <= next_transmit;
      read_requested          <= next_read_req;
      address_ack             <= next_ack;
      general_call_hit        <= next_gc;
      alert_response_hit      <= next_alert;
    end
  end

  // ****************************************
  // interrupt flag
  // ****************************************
  logic next_int_flag;

  // set wins over a clear in the same cycle so no match is lost
  always_comb begin
    next_int_flag = module_interrupt_flag;
    if (interrupt_flag_clear) begin
      next_int_flag = 1'b0;
    end
    if (match_event) begin
      next_int_flag = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      module_interrupt_flag <= 1'b0;
    end else begin
      module_interrupt_flag <= next_int_flag;
    end
  end

  // request gated by the enable; flag stays visible either way
  assign interrupt_request = module_interrupt_flag && module_interrupt_enable;

endmodule

// ===== iam_defines.svh
`ifndef IAM_DEFINES_SVH
`define IAM_DEFINES_SVH

// ****************************************
// address constants
// ****************************************
// five leading bits of a 10-bit first address byte
`define IAM_TEN_BIT_PREFIX      5'h1E
// general call is the all-zero 7-bit address
`define IAM_GENERAL_CALL_ADDR   7'h00
// alert response address, 0001100
`define IAM_ALERT_RESPONSE_ADDR 7'h0C
// a range register at zero switches range matching off
`define IAM_RANGE_OFF           7'h00
// direction bit values
`define IAM_DIR_WRITE           1'b0
`define IAM_DIR_READ            1'b1

// ****************************************
// field positions of an address byte
// ****************************************
`define IAM_DIR_BIT             0
`define IAM_ADDR_MSB            7
`define IAM_ADDR_LSB            1
`define IAM_PREFIX_MSB          7
`define IAM_PREFIX_LSB          3
`define IAM_UPPER_MSB           2
`define IAM_UPPER_LSB           1
// extension bit that goes into the second byte
`define IAM_EXT_LOW_BIT         0

// ****************************************
// reset values
// ****************************************
`define IAM_RESET_BYTE7         7'h00
`define IAM_RESET_COUNT         12'h000

`endif

// ===== iam_pkg.sv
package iam_pkg;

  // slave addressing progress
  typedef enum logic [2:0] {
    IAM_IDLE,
    IAM_FIRST_BYTE,
    IAM_SECOND_BYTE,
    IAM_ADDRESSED,
    IAM_IGNORE
  } iam_state_e;

  // one entry of the bus-rate table, counts in module clocks
  typedef struct packed {
    logic [11:0] scl_divider;
    logic [11:0] sda_hold;
    logic [11:0] start_hold;
    logic [11:0] stop_hold;
  } iam_rate_s;

endpackage

// ===== iam_addr_cmp.sv
// one enabled 7-bit address comparison; direction check is optional
module iam_addr_cmp #(
  parameter bit CHECK_DIR = 1'b0,
  parameter bit DIR_VALUE = 1'b0
) (
  // compare inputs
  input  wire logic [6:0] rx_addr,
  input  wire logic       rx_dir,
  input  wire logic [6:0] own_addr,
  input  wire logic       enable,
  // result
  output      logic       hit
);

  // address equal, enabled, and direction right where it matters
  assign hit = enable && (rx_addr == own_addr) && (!CHECK_DIR || (rx_dir == DIR_VALUE));

endmodule

// ===== iam_rate_lut.sv
// fixed bus-rate table; the select code picks divider and hold counts
module iam_rate_lut (
  // select code
  input  wire logic [5:0]         bus_rate_select,
  // decoded counts
  output      iam_pkg::iam_rate_s rate
);

  // each literal packs divider, sda hold, start hold, stop hold
  always_comb begin
    unique case (bus_rate_select)
      6'h00: rate = 48'h014_007_006_00B;
      6'h01: rate = 48'h016_007_007_00C;
      6'h02: rate = 48'h018_008_008_00D;
      6'h03: rate = 48'h01A_008_009_00E;
      6'h04: rate = 48'h01C_009_00A_00F;
      6'h05: rate = 48'h01E_009_00B_010;
      6'h06: rate = 48'h022_00A_00D_012;
      6'h07: rate = 48'h028_00A_010_015;
      6'h08: rate = 48'h01C_007_00A_00F;
      6'h09: rate = 48'h020_007_00C_011;
      6'h0A: rate = 48'h024_009_00E_013;
      6'h0B: rate = 48'h028_009_010_015;
      6'h0C: rate = 48'h02C_00B_012_017;
      6'h0D: rate = 48'h030_00B_014_019;
      6'h0E: rate = 48'h038_00D_018_01D;
      6'h0F: rate = 48'h044_00D_01E_023;
      6'h10: rate = 48'h030_009_012_019;
      6'h11: rate = 48'h038_009_016_01D;
      6'h12: rate = 48'h040_00D_01A_021;
      6'h13: rate = 48'h048_00D_01E_025;
      6'h14: rate = 48'h050_011_022_029;
      6'h15: rate = 48'h058_011_026_02D;
      6'h16: rate = 48'h068_015_02E_035;
      6'h17: rate = 48'h080_015_03A_041;
      6'h18: rate = 48'h050_009_026_029;
      6'h19: rate = 48'h060_009_02E_031;
      6'h1A: rate = 48'h070_011_036_039;
      6'h1B: rate = 48'h080_011_03E_041;
      6'h1C: rate = 48'h090_019_046_049;
      6'h1D: rate = 48'h0A0_019_04E_051;
      6'h1E: rate = 48'h0C0_021_05E_061;
      6'h1F: rate = 48'h0F0_021_076_079;
      6'h20: rate = 48'h0A0_011_04E_051;
      6'h21: rate = 48'h0C0_011_05E_061;
      6'h22: rate = 48'h0E0_021_06E_071;
      6'h23: rate = 48'h100_021_07E_081;
      6'h24: rate = 48'h120_031_08E_091;
      6'h25: rate = 48'h140_031_09E_0A1;
      6'h26: rate = 48'h180_041_0BE_0C1;
      6'h27: rate = 48'h1E0_041_0EE_0F1;
      6'h28: rate = 48'h140_021_09E_0A1;
      6'h29: rate = 48'h180_021_0BE_0C1;
      6'h2A: rate = 48'h1C0_041_0DE_0E1;
      6'h2B: rate = 48'h200_041_0FE_101;
      6'h2C: rate = 48'h240_061_11E_121;
      6'h2D: rate = 48'h280_061_13E_141;
      6'h2E: rate = 48'h300_081_17E_181;
      6'h2F: rate = 48'h3C0_081_1DE_1E1;
      6'h30: rate = 48'h280_041_13E_141;
      6'h31: rate = 48'h300_041_17E_181;
      6'h32: rate = 48'h380_081_1BE_1C1;
      6'h33: rate = 48'h400_081_1FE_201;
      6'h34: rate = 48'h480_0C1_23E_241;
      6'h35: rate = 48'h500_0C1_27E_281;
      6'h36: rate = 48'h600_101_2FE_301;
      6'h37: rate = 48'h780_101_3BE_3C1;
      6'h38: rate = 48'h500_081_27E_281;
      6'h39: rate = 48'h600_081_2FE_301;
      6'h3A: rate = 48'h700_101_37E_381;
      6'h3B: rate = 48'h800_101_3FE_401;
      6'h3C: rate = 48'h900_181_47E_481;
      6'h3D: rate = 48'hA00_181_4FE_501;
      6'h3E: rate = 48'hC00_201_5FE_601;
      6'h3F: rate = 48'hF00_201_77E_781;
    endcase
  end

endmodule

// ===== iam_addr_matcher_asserts.sv
// checker on the matcher's top ports
module iam_addr_matcher_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // bus events and controls
  input wire logic        start_seen,
  input wire logic        stop_seen,
  input wire logic        byte_done,
  input wire logic        module_interrupt_enable,
  input wire logic        interrupt_flag_clear,
  input wire logic [5:0]  bus_rate_select,
  // answers
  input wire logic        address_ack,
  input wire logic        addressed_as_slave_flag,
  input wire logic        slave_transmit,
  input wire logic        read_requested,
  input wire logic        general_call_hit,
  input wire logic        alert_response_hit,
  input wire logic        module_interrupt_flag,
  input wire logic        interrupt_request,
  input wire logic [11:0] scl_divider,
  input wire logic [11:0] sda_hold
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // an ack only follows a byte that no start or stop overrode
  ack_cause_a: assert property (address_ack |-> $past(byte_done) && !$past(start_seen) && !$past(stop_seen))
    else $error("ack without a deciding byte");
  stop_release_a: assert property (stop_seen |=> !addressed_as_slave_flag && !address_ack)
    else $error("still addressed after stop");
  flag_set_a: assert property (address_ack |-> module_interrupt_flag)
    else $error("accepted address without flag");
  flag_clear_a: assert property (interrupt_flag_clear |=> !module_interrupt_flag || address_ack)
    else $error("flag survived its clear");
  flag_hold_a: assert property (module_interrupt_flag && !interrupt_flag_clear |=> module_interrupt_flag)
    else $error("flag dropped by itself");
  irq_gate_a: assert property (interrupt_request == (module_interrupt_flag && module_interrupt_enable))
    else $error("request not flag and enable");
  rate_top_a: assert property (bus_rate_select == 6'h3F |=> scl_divider == 12'hF00 && sda_hold == 12'h201)
    else $error("top rate code decodes wrong");
  transmit_read_a: assert property (slave_transmit |-> read_requested && addressed_as_slave_flag)
    else $error("transmit without read address");
  gc_dir_a: assert property ($rose(general_call_hit) |-> !read_requested)
    else $error("general call with read direction");
  alert_dir_a: assert property ($rose(alert_response_hit) |-> read_requested)
    else $error("alert response with write direction");

  // main scenarios reached
  cover property (address_ack);
  cover property ($rose(slave_transmit));
  cover property ($rose(alert_response_hit));
endmodule

// ===== iam_master_model.sv
// far-side bus master, seen through the events of the bit engine
module iam_master_model (
  // clock from the bench
  input  wire logic       clock,
  // events towards the matcher
  output      logic       start_seen,
  output      logic       stop_seen,
  output      logic       byte_done,
  output      logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    start_seen = 1'b0;
    stop_seen  = 1'b0;
    byte_done  = 1'b0;
    rx_byte    = 8'hFF;
  end

  // one event (0 start, 1 stop, 2 byte) held for one full cycle from a falling edge;
  // the bench builds 10-bit bytes as prefix, upper bits, direction
  task automatic send(input logic [1:0] kind, input logic [7:0] b);
    @(negedge clock);
    start_seen = (kind == 2'h0);
    stop_seen  = (kind == 2'h1);
    byte_done  = (kind == 2'h2);
    rx_byte    = b;
    @(negedge clock);
    start_seen = 1'b0;
    stop_seen  = 1'b0;
    byte_done  = 1'b0;
    // stale data is inverted so an old byte never matches by chance
    rx_byte    = ~rx_byte;
  endtask
endmodule

// ===== tb_iam_addr_matcher.sv
// self-checking bench for the address matcher
module tb_iam_addr_matcher;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // signals
  // ****************************************
  logic        clock = 1'b0;
  logic        rst, start_seen, stop_seen, byte_done;
  logic [7:0]  rx_byte;
  logic [6:0]  primary_address, second_address, range_address;
  logic [2:0]  extension_bits;
  logic        extended_address_enable, second_address_enable, range_match_enable;
  logic        general_call_enable, alert_response_enable;
  logic        module_interrupt_enable, interrupt_flag_clear;
  logic [5:0]  bus_rate_select;
  logic        address_ack, addressed_as_slave_flag, slave_transmit, read_requested;
  logic        general_call_hit, alert_response_hit, module_interrupt_flag, interrupt_request;
  logic [11:0] scl_divider, sda_hold, start_hold, stop_hold;
  int          mismatches = 0;
  int          compares = 0;

  always #25 clock = ~clock;

  iam_addr_matcher dut_u (.*);
  iam_master_model m_u (.clock(clock), .start_seen(start_seen), .stop_seen(stop_seen),
    .byte_done(byte_done), .rx_byte(rx_byte));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // address byte, optionally after a start; returns in the cycle the answer stands,
  // since the one-cycle ack is gone again after the next rising edge
  task automatic addr(input bit with_start, input logic [7:0] b);
    if (with_start) m_u.send(2'h0, 8'h00);
    m_u.send(2'h2, b);
  endtask

  task automatic close_out();
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rate();
    logic [53:0] rows [5] = '{{6'h00, 48'h014_007_006_00B}, {6'h14, 48'h050_011_022_029},
      {6'h1F, 48'h0F0_021_076_079}, {6'h37, 48'h780_101_3BE_3C1}, {6'h3F, 48'hF00_201_77E_781}};
    for (int i = 0; i < 5; i++) begin
      @(negedge clock);
      bus_rate_select = rows[i][53:48];
      repeat (2) @(posedge clock);
      #1;
      chk(scl_divider, rows[i][47:36]);
      chk(sda_hold, rows[i][35:24]);
      chk(start_hold, rows[i][23:12]);
      chk(stop_hold, rows[i][11:0]);
    end
  endtask

  task automatic t_seven();
    @(negedge clock);
    primary_address = 7'h2A;
    module_interrupt_enable = 1'b1;
    addr(1, 8'h54);
    chk(address_ack, 1);
    chk(addressed_as_slave_flag, 1);
    chk(slave_transmit, 0);
    chk(interrupt_request, 1);
    @(posedge clock);
    #1;
    chk(address_ack, 0);
    @(negedge clock);
    module_interrupt_enable = 1'b0;
    interrupt_flag_clear = 1'b1;
    @(negedge clock);
    interrupt_flag_clear = 1'b0;
    chk(module_interrupt_flag, 0);
    m_u.send(2'h1, 8'h00);
    @(posedge clock);
    #1;
    chk(addressed_as_slave_flag, 0);
    addr(1, 8'h56);
    chk(address_ack, 0);
    m_u.send(2'h1, 8'h00);
  endtask

  task automatic t_ten();
    @(negedge clock);
    extended_address_enable = 1'b1;
    extension_bits = 3'b101;
    addr(1, 8'hF4);
    chk(address_ack, 1);
    chk(addressed_as_slave_flag, 0);
    chk(module_interrupt_flag, 1);
    addr(0, 8'hAA);
    chk(address_ack, 1);
    chk(addressed_as_slave_flag, 1);
    addr(1, 8'hF5);
    chk(address_ack, 1);
    chk(slave_transmit, 1);
    chk(read_requested, 1);
    addr(1, 8'h20);
    chk(addressed_as_slave_flag, 0);
    m_u.send(2'h1, 8'h00);
    addr(1, 8'hF4);
    addr(0, 8'hAB);
    chk(address_ack, 0);
    chk(addressed_as_slave_flag, 0);
    addr(1, 8'hF5);
    chk(address_ack, 0);
    addr(1, 8'hF0);
    chk(address_ack, 0);
    addr(1, 8'h54);
    chk(address_ack, 0);
    m_u.send(2'h1, 8'h00);
    @(negedge clock);
    extended_address_enable = 1'b0;
  endtask

  // rows: enables (general call, alert, second, range), byte, expected ack
  task automatic t_extra();
    logic [12:0] rows [12] = '{{4'h0, 8'h00, 1'b0}, {4'h8, 8'h00, 1'b1}, {4'h8, 8'h01, 1'b0},
      {4'h4, 8'h19, 1'b1}, {4'h0, 8'h19, 1'b0}, {4'h4, 8'h18, 1'b0}, {4'h2, 8'h66, 1'b1},
      {4'h0, 8'h66, 1'b0}, {4'h1, 8'h5A, 1'b1}, {4'h1, 8'h5C, 1'b0}, {4'h0, 8'h5A, 1'b0},
      {4'h0, 8'h54, 1'b1}};
    for (int i = 0; i < 12; i++) begin
      @(negedge clock);
      {general_call_enable, alert_response_enable, second_address_enable,
        range_match_enable} = rows[i][12:9];
      addr(1, rows[i][8:1]);
      chk(address_ack, rows[i][0]);
      if (rows[i][0]) begin
        chk(general_call_hit, rows[i][8:1] == 8'h00);
        chk(alert_response_hit, rows[i][8:1] == 8'h19);
      end
      m_u.send(2'h1, 8'h00);
    end
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst = 1'b1;
    {primary_address, second_address, range_address, extension_bits} = 24'h000000;
    {extended_address_enable, second_address_enable, range_match_enable} = 3'h0;
    {general_call_enable, alert_response_enable, interrupt_flag_clear} = 3'h0;
    module_interrupt_enable = 1'b0;
    bus_rate_select = 6'h00;
    second_address = 7'h33;
    range_address = 7'h2D; // range kept above the primary address
    repeat (20) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_rate();
    t_seven();
    t_ten();
    t_extra();
    close_out();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    mismatches++;
    close_out();
  end
endmodule

bind iam_addr_matcher iam_addr_matcher_asserts chk_u (.clock(clock), .rst(rst),
  .start_seen(start_seen), .stop_seen(stop_seen), .byte_done(byte_done),
  .module_interrupt_enable(module_interrupt_enable),
  .interrupt_flag_clear(interrupt_flag_clear), .bus_rate_select(bus_rate_select),
  .address_ack(address_ack), .addressed_as_slave_flag(addressed_as_slave_flag),
  .slave_transmit(slave_transmit), .read_requested(read_requested),
  .general_call_hit(general_call_hit), .alert_response_hit(alert_response_hit),
  .module_interrupt_flag(module_interrupt_flag), .interrupt_request(interrupt_request),
  .scl_divider(scl_divider), .sda_hold(sda_hold));
